/* rtl/interp_mod_top.sv */
`timescale 1ns/10ps
module interp_mod_top (
   input wire logic MCLK_IN,
   input wire logic RST_N_IN,
   input wire logic [interp_mod_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [interp_mod_pkg::REG_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [interp_mod_pkg::REG_W-1:0] REG_RDATA_OUT,
   input wire logic [interp_mod_pkg::DATA_W-1:0] PORT1_DATA_IN,
   input wire logic [interp_mod_pkg::DATA_W-1:0] PORT2_DATA_IN,
   input wire logic CHANNEL_SELECT_IN,
   output logic DATA_RATE_CLOCK_OUT,
   output logic SERIAL_PORT_DATA_OUT,
   output logic INTERLEAVED_RATE_CLOCK_OUT,
   output logic DRIVE_BOOST_OUT,
   output logic [interp_mod_pkg::DATA_W-1:0] I_DAC_OUT,
   output logic [interp_mod_pkg::DATA_W-1:0] Q_DAC_OUT
);
   import interp_mod_pkg::*;

   typedef logic signed [DATA_W-1:0] sample_t;

   // ---------------------------------------------------------------
   // Helper functions.
   // ---------------------------------------------------------------
   function automatic logic [4:0] f_period(input logic [1:0] code, input logic stuff);
      f_period = (5'h01 << code) << stuff;
   endfunction : f_period

   function automatic sample_t f_avg(input sample_t a, input sample_t b);
      logic signed [DATA_W:0] sum;
      sum = {a[DATA_W-1], a} + {b[DATA_W-1], b};
      f_avg = sum[DATA_W:1];
   endfunction : f_avg

   function automatic sample_t f_scale(input sample_t x);
      logic signed [DATA_W+9:0] prod;
      prod = x * $signed({1'b0, SQRT_HALF});
      f_scale = prod[DATA_W+7:8];
   endfunction : f_scale

   function automatic sample_t f_mod(input sample_t x, input logic [1:0] code,
                                     input logic [2:0] ph);
      sample_t h;
      h = f_scale(x);
      f_mod = x;
      unique case (code)
         2'b00, 2'b01: f_mod = ph[0] ? -x : x;
         2'b10: begin
            unique case (ph[1:0])
               2'b00, 2'b10: f_mod = '0;
               2'b01: f_mod = x;
               2'b11: f_mod = -x;
            endcase
         end
         2'b11: begin
            unique case (ph)
               3'h0, 3'h4: f_mod = '0;
               3'h1, 3'h3, 3'h7: f_mod = h;
               3'h2: f_mod = x;
               3'h5: f_mod = -h;
               3'h6: f_mod = -x;
            endcase
         end
      endcase
   endfunction : f_mod

   // ---------------------------------------------------------------
   // Configuration registers.
   // ---------------------------------------------------------------
   logic [REG_W-1:0] interp_q;
   logic [REG_W-1:0] clkctl_q;
   logic [REG_W-1:0] pinsel_q;
   logic [REG_W-1:0] pll_q;
   logic wr_interp;
   logic wr_clkctl;
   logic restart;

   assign wr_interp = REG_WR_IN && (REG_ADDR_IN == ADDR_INTERP);
   assign wr_clkctl = REG_WR_IN && (REG_ADDR_IN == ADDR_CLKCTL);
   assign restart = wr_interp || wr_clkctl;

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         interp_q <= INTERP_RESET;
         clkctl_q <= CLKCTL_RESET;
         pinsel_q <= PINSEL_RESET;
         pll_q <= PLL_RESET;
      end else if (REG_WR_IN) begin
         if (REG_ADDR_IN == ADDR_INTERP) interp_q <= REG_WDATA_IN;
         if (REG_ADDR_IN == ADDR_CLKCTL) clkctl_q <= REG_WDATA_IN;
         if (REG_ADDR_IN == ADDR_PINSEL) pinsel_q <= REG_WDATA_IN;
         if (REG_ADDR_IN == ADDR_PLL) pll_q <= REG_WDATA_IN;
      end
   end

   // ---------------------------------------------------------------
   // Decoded settings.
   // ---------------------------------------------------------------
   logic one_port;
   logic stuff;
   logic mod_on;
   logic pll_on;
   logic [1:0] eff;
   logic forced;

   assign one_port = clkctl_q[ONE_PORT_BIT];
   assign stuff = interp_q[STUFF_BIT];
   assign mod_on = |interp_q[MOD_LSB +: 2];
   assign pll_on = pll_q[PLL_BIT];
   assign forced = one_port && (interp_q[INTERP_LSB +: 2] == 2'b00);
   assign eff = forced ? 2'b01 : interp_q[INTERP_LSB +: 2];

   // ---------------------------------------------------------------
   // Clock divider and sample phase.
   // ---------------------------------------------------------------
   logic [4:0] n_clk;
   logic [4:0] half;
   logic [4:0] quarter;
   logic [4:0] c_q;
   logic [4:0] c_d;
   logic [2:0] ph_q;
   logic [3:0] m;
   logic samp_tick;
   logic in_tick;
   logic word_tick;

   assign n_clk = f_period(eff, stuff);
   assign half = ((n_clk >> 1) == 5'h00) ? 5'h01 : (n_clk >> 1);
   assign quarter = ((n_clk >> 2) == 5'h00) ? 5'h01 : (n_clk >> 2);
   assign c_d = restart ? COUNT_RESET :
                (c_q == n_clk - 5'h01) ? COUNT_RESET : 5'(c_q + 5'h01);
   assign samp_tick = !stuff || !c_q[0];
   assign m = stuff ? c_q[4:1] : c_q[3:0];
   assign in_tick = (c_q == COUNT_RESET);
   assign word_tick = one_port && ((c_q & (half - 5'h01)) == 5'h00);

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         c_q <= COUNT_RESET;
      end else begin
         c_q <= c_d;
      end
   end

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         ph_q <= PHASE_RESET;
      end else if (restart) begin
         ph_q <= PHASE_RESET;
      end else if (samp_tick) begin
         ph_q <= 3'(ph_q + 3'h1);
      end
   end

   // ---------------------------------------------------------------
   // Input synchronisers.
   // ---------------------------------------------------------------
   sample_t p1_meta_q;
   sample_t p1_q;
   sample_t p2_meta_q;
   sample_t p2_q;
   logic sel_meta_q;
   logic sel_q;

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         p1_meta_q <= '0;
         p1_q <= '0;
         p2_meta_q <= '0;
         p2_q <= '0;
         sel_meta_q <= 1'b0;
         sel_q <= 1'b0;
      end else begin
         p1_meta_q <= PORT1_DATA_IN;
         p1_q <= p1_meta_q;
         p2_meta_q <= PORT2_DATA_IN;
         p2_q <= p2_meta_q;
         sel_meta_q <= CHANNEL_SELECT_IN;
         sel_q <= sel_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Interleaved word steering and pairing.
   // ---------------------------------------------------------------
   sample_t last_i_q;
   sample_t last_q_q;
   sample_t pair_i_q;
   sample_t pair_q_q;
   logic to_q;

   assign to_q = sel_q ^ clkctl_q[SWAP_BIT];

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         last_i_q <= '0;
         last_q_q <= '0;
         pair_i_q <= '0;
         pair_q_q <= '0;
      end else if (word_tick) begin
         if (!to_q) begin
            last_i_q <= p1_q;
            if (clkctl_q[PAIR_BIT]) begin
               pair_i_q <= p1_q;
               pair_q_q <= last_q_q;
            end
         end else begin
            last_q_q <= p1_q;
            if (!clkctl_q[PAIR_BIT]) begin
               pair_i_q <= last_i_q;
               pair_q_q <= p1_q;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Channel input capture.
   // ---------------------------------------------------------------
   sample_t chan_q [2];

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         chan_q[0] <= '0;
         chan_q[1] <= '0;
      end else if (in_tick) begin
         chan_q[0] <= one_port ? pair_i_q : p1_q;
         chan_q[1] <= one_port ? pair_q_q : p2_q;
      end
   end

   // ---------------------------------------------------------------
   // Half-band interpolation cascade.
   // ---------------------------------------------------------------
   sample_t st_in_q [2][3];
   sample_t st_hold_q [2][3];
   sample_t st_out_q [2][3];
   sample_t filt [2];

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 3; s++) begin
               st_in_q[ch][s] <= '0;
               st_hold_q[ch][s] <= '0;
               st_out_q[ch][s] <= '0;
            end
         end
      end else if (samp_tick) begin
         for (int ch = 0; ch < 2; ch++) begin
            for (int s = 0; s < 3; s++) begin
               logic [3:0] p;
               p = (4'h1 << eff) >> s;
               if (s < int'(eff)) begin
                  if ((m & (p - 4'h1)) == 4'h0) begin
                     if (s == 0) begin
                        st_in_q[ch][s] <= chan_q[ch];
                     end else begin
                        st_in_q[ch][s] <= st_out_q[ch][(s + 2) % 3];
                     end
                     st_hold_q[ch][s] <= st_in_q[ch][s];
                     st_out_q[ch][s] <= st_in_q[ch][s];
                  end else if ((m & (p - 4'h1)) == (p >> 1)) begin
                     st_out_q[ch][s] <= f_avg(st_hold_q[ch][s], st_in_q[ch][s]);
                  end
               end
            end
         end
      end
   end

   always_comb begin
      for (int ch = 0; ch < 2; ch++) begin
         filt[ch] = (eff == 2'b00) ? chan_q[ch] : st_out_q[ch][eff-2'b01];
      end
   end

   // ---------------------------------------------------------------
   // Modulator and zero stuffing.
   // ---------------------------------------------------------------
   sample_t mod_q [2];

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         mod_q[0] <= '0;
         mod_q[1] <= '0;
      end else if (samp_tick) begin
         for (int ch = 0; ch < 2; ch++) begin
            mod_q[ch] <= mod_on ? f_mod(filt[ch], eff, ph_q) : filt[ch];
         end
      end
   end

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         I_DAC_OUT <= MIDSCALE;
         Q_DAC_OUT <= MIDSCALE;
      end else begin
         I_DAC_OUT <= (stuff && c_q[0]) ? MIDSCALE : (mod_q[0] ^ MIDSCALE);
         Q_DAC_OUT <= (stuff && c_q[0]) ? MIDSCALE : (mod_q[1] ^ MIDSCALE);
      end
   end

   // ---------------------------------------------------------------
   // Clock outputs.
   // ---------------------------------------------------------------
   logic dclk_lvl;
   logic iclk_lvl;

   assign dclk_lvl = (c_d < half) ^ clkctl_q[DCLK_INV_BIT];
   assign iclk_lvl = ((c_d & (half - 5'h01)) < quarter) ^ clkctl_q[ICLK_INV_BIT];

   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         DATA_RATE_CLOCK_OUT <= 1'b0;
         SERIAL_PORT_DATA_OUT <= 1'b0;
         INTERLEAVED_RATE_CLOCK_OUT <= 1'b0;
         DRIVE_BOOST_OUT <= 1'b0;
      end else begin
         DATA_RATE_CLOCK_OUT <= !pll_on && !one_port && !pinsel_q[SDO_CLK_BIT] && dclk_lvl;
         SERIAL_PORT_DATA_OUT <= !pll_on && !one_port && pinsel_q[SDO_CLK_BIT] && dclk_lvl;
         INTERLEAVED_RATE_CLOCK_OUT <= !pll_on && one_port && iclk_lvl;
         DRIVE_BOOST_OUT <= clkctl_q[DRIVE_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Register read port.
   // ---------------------------------------------------------------
   always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         REG_RDATA_OUT <= '0;
      end else if (REG_RD_IN) begin
         unique case (REG_ADDR_IN)
            ADDR_INTERP: REG_RDATA_OUT <= interp_q;
            ADDR_CLKCTL: REG_RDATA_OUT <= clkctl_q;
            ADDR_PINSEL: REG_RDATA_OUT <= pinsel_q;
            ADDR_PLL: REG_RDATA_OUT <= pll_q;
            ADDR_STATUS: REG_RDATA_OUT <= {1'b0, ph_q, stuff, forced, eff};
            default: REG_RDATA_OUT <= '0;
         endcase
      end else begin
         REG_RDATA_OUT <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (!RST_N_IN);

   a_mod_two_step: assert property (samp_tick && mod_on && eff == 2'b01 && ph_q[0] |=> mod_q[0] == -$past(filt[0])) else $error("twofold modulation sign wrong");
   a_mod_four_zero: assert property (samp_tick && mod_on && eff == 2'b10 && !ph_q[0] |=> mod_q[1] == '0) else $error("fourfold modulation zero missing");
   a_mod_eight_peak: assert property (samp_tick && mod_on && eff == 2'b11 && ph_q == 3'h6 |=> mod_q[0] == -$past(filt[0])) else $error("eightfold negative peak wrong");
   a_stuff_midscale: assert property (stuff && c_q[0] |=> I_DAC_OUT == MIDSCALE && Q_DAC_OUT == MIDSCALE) else $error("stuffed sample not midscale");
   a_two_port_capture: assert property (in_tick && !one_port |=> chan_q[0] == $past(p1_q) && chan_q[1] == $past(p2_q)) else $error("two-port capture wrong");
   a_select_route: assert property (word_tick && (sel_q ^ clkctl_q[SWAP_BIT]) |=> last_q_q == $past(p1_q) && $stable(last_i_q)) else $error("select routing wrong");
   a_one_port_rate: assert property (one_port |-> eff != 2'b00) else $error("onefold used in one-port mode");
   a_pair_q_first: assert property (word_tick && !to_q && clkctl_q[PAIR_BIT] |=> pair_q_q == $past(last_q_q)) else $error("Q-first pairing wrong");
   a_dclk_phase: assert property (!pll_on && !one_port && !pinsel_q[SDO_CLK_BIT] && !clkctl_q[DCLK_INV_BIT] && !restart && $rose(DATA_RATE_CLOCK_OUT) |-> c_q == COUNT_RESET) else $error("data clock edge off phase");
   a_restart_seq: assert property (wr_interp |=> c_q == COUNT_RESET && ph_q == PHASE_RESET) else $error("sequence not restarted");

   c_one_port_stuff: cover property (one_port && stuff && word_tick);
   c_eight_mod: cover property (mod_on && eff == 2'b11 && ph_q == 3'h7);
   c_sdo_clock: cover property ($rose(SERIAL_PORT_DATA_OUT));
   c_pair_q_first: cover property (word_tick && !to_q && clkctl_q[PAIR_BIT]);
   c_swap_select: cover property (word_tick && clkctl_q[SWAP_BIT]);
endmodule : interp_mod_top

/* rtl/interp_mod_pkg.sv */
// How it works
// - Pairing 0: I first, pair presented together.
// - Pairing 1: Q pairs with following I.
// - Data clock is clock over rate, doubled stuffed; held level at onefold unstuffed.
// - Both ports captured on data clock rise.
// - 03h bit 7 moves clock to serial pin.
// - Data clock invert and drive same, PLL off.
// - One-port clock runs at twice channel rate; held level at twofold unstuffed.
// - Select 0 routes word to I, 1 to Q.
// - Register 02h bit 1 swaps select meaning.
// - No onefold interpolation in one-port mode.
// - One-port invert, drive, pairing same, PLL off.
// - Three cascaded half-band stages per channel.
// - Register 01h bits 7:6 select interpolation rate.
// - Register 01h bits 5:4 enable modulation when nonzero.
// - Twofold modulation multiplies by +1, -1.
// - Fourfold modulation multiplies by 0, +1, 0, -1.
// - Eightfold modulation uses printed eight-step sequence.
// - Filters come before the modulator.
// - Register 02h bit 0 sets pair ordering.
// - Register 02h bit 4 inverts data clock.
// - Register 02h bit 2 inverts interleaved clock.
// - Zero stuffing inserts midscale after each sample.
package interp_mod_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int REG_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_INTERP = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_CLKCTL = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_PINSEL = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_PLL = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h05;
   localparam logic [REG_W-1:0] INTERP_RESET = 8'h00;
   localparam logic [REG_W-1:0] CLKCTL_RESET = 8'h00;
   localparam logic [REG_W-1:0] PINSEL_RESET = 8'h00;
   localparam logic [REG_W-1:0] PLL_RESET = 8'h00;
   localparam int INTERP_LSB = 6;
   localparam int MOD_LSB = 4;
   localparam int STUFF_BIT = 3;
   localparam int PAIR_BIT = 0;
   localparam int SWAP_BIT = 1;
   localparam int ICLK_INV_BIT = 2;
   localparam int DCLK_INV_BIT = 4;
   localparam int DRIVE_BIT = 5;
   localparam int ONE_PORT_BIT = 6;
   localparam int SDO_CLK_BIT = 7;
   localparam int PLL_BIT = 7;
   localparam logic [DATA_W-1:0] MIDSCALE = 16'h8000;
   localparam logic [8:0] SQRT_HALF = 9'h0B5;
   localparam logic [4:0] COUNT_RESET = 5'h00;
   localparam logic [2:0] PHASE_RESET = 3'h0;
endpackage : interp_mod_pkg

/* verification/iq_source_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Upstream sample source.
// ----------------------------------------
module iq_source_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic one_port_in,
   input wire logic inv_in,
   input wire logic sync_clk_in,
   input wire logic [interp_mod_pkg::DATA_W-1:0] i_word_in,
   input wire logic [interp_mod_pkg::DATA_W-1:0] q_word_in,
   output logic [interp_mod_pkg::DATA_W-1:0] port1_out,
   output logic [interp_mod_pkg::DATA_W-1:0] port2_out,
   output logic sel_out
);
   import interp_mod_pkg::*;
   logic sync_q;
   logic active_edge;
   assign active_edge = inv_in ? (sync_q & ~sync_clk_in) : (~sync_q & sync_clk_in);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_q <= 1'b0;
         port1_out <= 16'h0000;
         port2_out <= 16'h5A5A;
         sel_out <= 1'b0;
      end else begin
         sync_q <= sync_clk_in;
         if (one_port_in) begin
            port2_out <= ~port2_out;
            if (active_edge) begin
               sel_out <= ~sel_out;
               port1_out <= sel_out ? i_word_in : q_word_in;
            end
         end else if (active_edge) begin
            port1_out <= i_word_in;
            port2_out <= q_word_in;
         end
      end
   end
endmodule : iq_source_model

/* verification/dual_channel_interp_modulator_input_test.sv */
`timescale 1ns/10ps
module dual_channel_interp_modulator_input_test;
   import interp_mod_pkg::*;
   localparam logic [DATA_W-1:0] I_WORD = 16'h1000;
   localparam logic [DATA_W-1:0] Q_WORD = 16'hF000;
   localparam int F1[8] = '{256, 0, 0, 0, 0, 0, 0, 0};
   localparam int F2[8] = '{256, -256, 0, 0, 0, 0, 0, 0};
   localparam int F4[8] = '{0, 256, 0, -256, 0, 0, 0, 0};
   localparam int F8[8] = '{0, 181, 256, 181, 0, -181, -256, 181};
   logic mclk;
   logic rst_n;
   logic [ADDR_W-1:0] addr;
   logic [REG_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [REG_W-1:0] rdata;
   logic [DATA_W-1:0] port1;
   logic [DATA_W-1:0] port2;
   logic sel;
   logic dclk;
   logic sdo;
   logic iclk;
   logic boost;
   logic [DATA_W-1:0] i_dac;
   logic [DATA_W-1:0] q_dac;
   logic one_port;
   logic inv;
   logic [DATA_W-1:0] i_word;
   logic [DATA_W-1:0] q_word;
   int n_errors;
   int num_checks;
   // ----------------------------------------
   // Clock, design and source.
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   interp_mod_top i_dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
      .PORT1_DATA_IN(port1), .PORT2_DATA_IN(port2), .CHANNEL_SELECT_IN(sel),
      .DATA_RATE_CLOCK_OUT(dclk), .SERIAL_PORT_DATA_OUT(sdo),
      .INTERLEAVED_RATE_CLOCK_OUT(iclk), .DRIVE_BOOST_OUT(boost), .I_DAC_OUT(i_dac),
      .Q_DAC_OUT(q_dac));
   iq_source_model i_src (.clk_in(mclk), .rst_n_in(rst_n), .one_port_in(one_port),
      .inv_in(inv), .sync_clk_in(dclk | sdo | iclk), .i_word_in(i_word), .q_word_in(q_word),
      .port1_out(port1), .port2_out(port2), .sel_out(sel));
   // ----------------------------------------
   // Shared tasks.
   // ----------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      check({8'h00, rdata & m}, {8'h00, exp});
   endtask : reg_read
   function automatic logic pick(input int w);
      return (w == 0) ? dclk : ((w == 1) ? sdo : iclk);
   endfunction : pick
   task automatic measure(input int w, input int exp_rises, input int exp_high);
      int rises;
      int high;
      logic prev;
      rises = 0;
      high = 0;
      repeat (8) @(posedge mclk);
      #1 prev = pick(w);
      repeat (32) begin
         @(posedge mclk);
         #1;
         if (pick(w) === 1'b1 && prev === 1'b0) rises++;
         if (pick(w) === 1'b1) high++;
         prev = pick(w);
      end
      check(16'(rises), 16'(exp_rises));
      check(16'(high), 16'(exp_high));
   endtask : measure
   function automatic logic [15:0] dac_word(input logic [15:0] v, input int f);
      int prod;
      prod = $signed(v) * f / 256;
      return 16'(prod) ^ MIDSCALE;
   endfunction : dac_word
   task automatic run_mod(input logic [7:0] cfg, input int len, input int f[8],
         input logic [15:0] vi, input logic [15:0] vq);
      logic [15:0] exp_i[16];
      logic [15:0] exp_q[16];
      logic [15:0] got_i[16];
      logic [15:0] got_q[16];
      int p;
      int ok;
      int bad;
      p = cfg[STUFF_BIT] ? 2 * len : len;
      for (int k = 0; k < p; k++) begin
         exp_i[k] = (cfg[STUFF_BIT] && k % 2 == 1) ? MIDSCALE :
            dac_word(vi, f[cfg[STUFF_BIT] ? k / 2 : k]);
         exp_q[k] = (cfg[STUFF_BIT] && k % 2 == 1) ? MIDSCALE :
            dac_word(vq, f[cfg[STUFF_BIT] ? k / 2 : k]);
      end
      reg_write(ADDR_INTERP, cfg);
      ok = 0;
      for (int t = 0; t < 20 && ok == 0; t++) begin
         repeat (32) @(posedge mclk);
         for (int s = 0; s < 16; s++) begin
            @(posedge mclk);
            #1;
            got_i[s] = i_dac;
            got_q[s] = q_dac;
         end
         for (int o = 0; o < p; o++) begin
            bad = 0;
            for (int s = 0; s < 16; s++) begin
               if (got_i[s] !== exp_i[(s + o) % p] || got_q[s] !== exp_q[(s + o) % p]) bad = 1;
            end
            if (bad == 0) ok = 1;
         end
      end
      check(16'(ok), 16'h0001);
      $display("test sample stream %h done", cfg);
   endtask : run_mod
   task automatic pair_lag(input logic [7:0] ctl, input int lag);
      int ti;
      int tq;
      ti = -1;
      tq = -1;
      reg_write(ADDR_CLKCTL, ctl);
      reg_write(ADDR_INTERP, 8'h80);
      repeat (48) @(posedge mclk);
      #1;
      for (int t = 0; t < 8 && sel !== 1'b1; t++) begin
         @(posedge mclk);
         #1;
      end
      check({15'h0000, sel}, 16'h0001);
      i_word <= 16'h2000;
      q_word <= 16'hE000;
      for (int t = 0; t < 64; t++) begin
         @(posedge mclk);
         #1;
         if (ti < 0 && i_dac !== (I_WORD ^ MIDSCALE)) ti = t;
         if (tq < 0 && q_dac !== (Q_WORD ^ MIDSCALE)) tq = t;
      end
      check(16'(ti >= 0 && tq >= 0), 16'h0001);
      check(16'(tq - ti), 16'(lag));
      i_word <= I_WORD;
      q_word <= Q_WORD;
      $display("test pairing %h done", ctl);
   endtask : pair_lag
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // Main sequence.
   // ----------------------------------------
   initial begin
      #1000000;
      n_errors++;
      $display("test sequence timed out");
      tally_and_finish();
   end
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      one_port = 1'b0;
      inv = 1'b0;
      i_word = I_WORD;
      q_word = Q_WORD;
      n_errors = 0;
      num_checks = 0;
      @(posedge mclk);
      #1 check(i_dac, MIDSCALE);
      check({15'h0000, dclk}, 16'h0000);
      @(posedge mclk);
      rst_n <= 1'b1;
      reg_read(ADDR_INTERP, INTERP_RESET, 8'hFF);
      reg_read(ADDR_CLKCTL, CLKCTL_RESET, 8'hFF);
      reg_read(ADDR_PINSEL, PINSEL_RESET, 8'hFF);
      reg_read(ADDR_PLL, PLL_RESET, 8'hFF);
      reg_write(8'h7F, 8'hFF);
      reg_read(8'h7F, 8'h00, 8'hFF);
      @(posedge mclk);
      #1 check({8'h00, rdata}, 16'h0000);
      reg_write(ADDR_INTERP, 8'hC8);
      reg_read(ADDR_INTERP, 8'hC8, 8'hFF);
      $display("test registers done");
      for (int k = 0; k < 8; k++) begin
         reg_write(ADDR_INTERP, {2'(k % 4), 2'b00, 1'(k / 4), 3'b000});
         measure(0, (k == 0) ? 0 : 32 / ((1 << (k % 4)) * (1 + k / 4)), (k == 0) ? 32 : 16);
      end
      reg_write(ADDR_INTERP, 8'h00);
      reg_write(ADDR_CLKCTL, 8'h30);
      measure(0, 0, 0);
      check({15'h0000, boost}, 16'h0001);
      reg_write(ADDR_CLKCTL, 8'h00);
      reg_write(ADDR_INTERP, 8'h40);
      reg_write(ADDR_PINSEL, 8'h80);
      measure(1, 16, 16);
      measure(0, 0, 0);
      reg_write(ADDR_PINSEL, 8'h00);
      $display("test data clock done");
      run_mod(8'h40, 1, F1, I_WORD, Q_WORD);
      run_mod(8'h50, 2, F2, I_WORD, Q_WORD);
      run_mod(8'hA0, 4, F4, I_WORD, Q_WORD);
      run_mod(8'hF0, 8, F8, I_WORD, Q_WORD);
      run_mod(8'h58, 2, F2, I_WORD, Q_WORD);
      run_mod(8'h20, 2, F2, I_WORD, Q_WORD);
      one_port <= 1'b1;
      reg_write(ADDR_CLKCTL, 8'h40);
      run_mod(8'h80, 1, F1, I_WORD, Q_WORD);
      measure(2, 16, 16);
      measure(0, 0, 0);
      reg_write(ADDR_CLKCTL, 8'h42);
      run_mod(8'h80, 1, F1, Q_WORD, I_WORD);
      reg_write(ADDR_CLKCTL, 8'h41);
      run_mod(8'h80, 1, F1, I_WORD, Q_WORD);
      pair_lag(8'h40, 0);
      pair_lag(8'h41, 4);
      inv <= 1'b1;
      reg_write(ADDR_CLKCTL, 8'h64);
      run_mod(8'h80, 1, F1, I_WORD, Q_WORD);
      check({15'h0000, boost}, 16'h0001);
      reg_write(ADDR_INTERP, 8'h00);
      measure(2, 0, 0);
      reg_read(ADDR_STATUS, 8'h05, 8'h07);
      reg_write(ADDR_CLKCTL, 8'h40);
      measure(2, 0, 32);
      $display("test one port done");
      tally_and_finish();
   end
endmodule : dual_channel_interp_modulator_input_test
